// [testbench/meas_source.sv]
// Behavioural source of the residual and phase current phasors.
`default_nettype none
module meas_source
	import efo_pkg::*;
(
	input  wire logic                   aclk,   // Sample clock.
	input  wire logic signed [PW-1:0]   lvl_r1, // Residual one level.
	input  wire logic signed [PW-1:0]   lvl_r2, // Residual two level.
	input  wire logic [2:0][PW-1:0]     lvl_ph, // Phase levels, L1 at index 0.
	output var phasor_t                 r1,     // Residual one phasor.
	output var phasor_t                 r2,     // Residual two phasor.
	output var phasor_t [2:0]           ph      // Phase phasors.
);
	timeunit 1ns;
	timeprecision 1ps;
	// All phasors sit on the real axis, so the calculated residual is the plain sum.
	always_ff @(posedge aclk)
	begin
		r1 <= {lvl_r1, {PW{1'b0}}};
		r2 <= {lvl_r2, {PW{1'b0}}};
		for (int i = 0; i < 3; i++)
			ph[i] <= {lvl_ph[i], {PW{1'b0}}};
	end
endmodule : meas_source
`default_nettype wire

// [testbench/tb_earth_fault_overcurrent_stages.sv]
// Self-checking bench of the earth fault overcurrent stages.
`default_nettype none
module tb_earth_fault_overcurrent_stages
	import efo_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 4;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
	logic awready, wready, arready, event_valid;
	logic [AXI_AW-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, start, trip;
	logic [1:0] bresp, rresp, event_stage, ev_stage;
	logic [2:0] line_alarm, line_fault;
	class_t event_code, ev_code;
	logic signed [PW-1:0] r1l, r2l;
	logic [2:0][PW-1:0] phl;
	phasor_t r1, r2;
	phasor_t [2:0] ph;
	int err_count, cmp_count;
	int ev_n = 0;

	earth_fault_overcurrent_stages #(.TICK_CYCLES(TK)) earth_fault_overcurrent_stages_inst (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.residual_input_one(r1), .residual_input_two(r2), .phase_cur(ph), .start(start),
		.trip(trip), .line_alarm(line_alarm), .line_fault(line_fault),
		.event_valid(event_valid), .event_stage(event_stage), .event_code(event_code));
	meas_source meas_source_inst (.aclk(aclk), .lvl_r1(r1l), .lvl_r2(r2l), .lvl_ph(phl),
		.r1(r1), .r2(r2), .ph(ph));

	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// Events are single-cycle pulses, so they are latched here for the scenarios.
	always @(posedge aclk)
		if (event_valid === 1'b1)
		begin
			ev_n <= ev_n + 1;
			ev_stage <= event_stage;
			ev_code <= event_code;
		end

	task wrap_up();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up

	task hang();
		$display("Error wait ran out of cycles");
		err_count++;
		wrap_up();
	endtask : hang

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task idle(input int k);
		repeat (k) @(posedge aclk);
	endtask : idle

	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge aclk) n++; while (awready !== 1'b1 && n < 50);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge aclk) n++; while (bvalid !== 1'b1 && n < 50);
		r = bresp;
		bready <= 1'b0;
		if (n >= 50) hang();
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk) n++; while (arready !== 1'b1 && n < 50);
		arvalid <= 1'b0;
		do @(posedge aclk) n++; while (rvalid !== 1'b1 && n < 50);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n >= 50) hang();
	endtask : rd

	task automatic wait_bit(input bit trp, input int b, input logic v, output int n);
		n = 0;
		do @(posedge aclk) n++; while ((trp ? trip[b] : start[b]) !== v && n < 1000);
		if (n >= 1000) hang();
	endtask : wait_bit

	function automatic logic [11:0] sa(input int g, input int s);
		return 12'(256 + g * 32 + s * 8);
	endfunction : sa

	function automatic logic [31:0] cfg(input int thr, input int src, input bit fpd);
		return 32'(thr) | (32'(src) << CFG_SRC) | (32'(fpd) << CFG_FPD);
	endfunction : cfg

	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		chk("outputs after reset", {line_alarm, line_fault, trip, start}, 32'h0);
		rd(CTRL_OFF, d, r);
		chk("ctrl reset", d, 32'h0);
		rd(sa(0, 0), d, r);
		chk("cfg reset", d, CFG_RST);
		rd(sa(3, 3) + 12'h004, d, r);
		chk("tim reset", d, TIM_RST);
		rd(12'h0f0, d, r);
		chk("unmapped rresp", r, BR_SLVERR);
		chk("unmapped rdata", d, 32'h0);
		wr(12'h0f0, 32'h1, r);
		chk("unmapped bresp", r, BR_SLVERR);
		wr(STATUS_OFF, 32'hff, r);
		chk("status write", r, BR_OKAY);
		rd(STATUS_OFF, d, r);
		chk("status read only", d, 32'h0);
		wr(CTRL_OFF, 32'h3, r);
		rd(CTRL_OFF, d, r);
		chk("ctrl group", d, 32'h3);
		wstrb <= 4'he;
		wr(CTRL_OFF, 32'h0, r);
		wstrb <= 4'hf;
		rd(CTRL_OFF, d, r);
		chk("ctrl strobe", d, 32'h3);
		wr(CTRL_OFF, 32'h0, r);
	endtask : t_regs

	task automatic t_trip();
		int n;
		r1l <= 18'sd1200;
		wait_bit(0, 0, 1'b1, n);
		chk("start latency", n <= 5, 1);
		chk("all stages start", start, 4'hf);
		wait_bit(1, 0, 1'b1, n);
		chk("trip delay", n >= 11 && n <= 18, 1);
		idle(1);
		chk("all stages trip", trip, 4'hf);
		r1l <= 18'sd970;
		idle(4);
		chk("held above hysteresis", {trip, start}, 8'hff);
		r1l <= 18'sd900;
		idle(4);
		chk("reset below hysteresis", {trip, start}, 8'h00);
		r1l <= 18'sd1200;
		wait_bit(0, 0, 1'b1, n);
		idle(6);
		r1l <= 18'sd0;
		wait_bit(0, 0, 1'b0, n);
		r1l <= 18'sd1200;
		wait_bit(0, 0, 1'b1, n);
		wait_bit(1, 0, 1'b1, n);
		chk("delay restarted", n >= 11, 1);
		r1l <= 18'sd0;
		idle(4);
	endtask : t_trip

	task automatic t_group();
		logic [1:0] r;
		wr(sa(1, 0), cfg(3000, 0, 0), r);
		wr(CTRL_OFF, 32'h1, r);
		r1l <= 18'sd2000;
		idle(6);
		chk("group one active", start, 4'he);
		wr(CTRL_OFF, 32'h0, r);
		idle(4);
		chk("group zero active", start, 4'hf);
		r1l <= 18'sd0;
		idle(4);
	endtask : t_group

	task automatic t_source();
		logic [1:0] r;
		wr(sa(0, 0), cfg(1000, SRC_R2, 0), r);
		r1l <= 18'sd2000;
		idle(6);
		chk("input two ignores one", start[0], 1'b0);
		r2l <= 18'sd2000;
		idle(6);
		chk("input two starts", start[0], 1'b1);
		r1l <= 18'sd0;
		r2l <= 18'sd0;
		wr(sa(0, 0), cfg(1000, SRC_CALC, 0), r);
		phl <= {3{18'd300}};
		idle(6);
		chk("calc below", start[0], 1'b0);
		phl <= {3{18'd400}};
		idle(6);
		chk("calc sum starts", start[0], 1'b1);
		phl <= '0;
		idle(4);
	endtask : t_source

	task automatic t_class();
		logic [31:0] d, e;
		logic [1:0] r;
		int n, e0;
		for (int p = 0; p < 5; p++)
		begin
			wr(sa(0, 0), cfg(1000, 0, p < 4), r);
			phl <= {3{18'd100}};
			idle(4);
			e0 = ev_n;
			e = (p < 3) ? 32'(p) : 32'(CL_REV);
			r1l <= 18'sd2000;
			wait_bit(0, 0, 1'b1, n);
			if (p < 3) phl[p] <= 18'd3000;
			wait_bit(1, 0, 1'b1, n);
			idle(2);
			chk("event count", ev_n - e0, p < 4);
			if (p < 4)
			begin
				chk("event code", ev_code, e);
				chk("event stage", ev_stage, 2'h0);
				rd(CLASS_OFF, d, r);
				chk("class register", d[3:0], {1'b1, e[2:0]});
			end
			if (p < 3)
			begin
				chk("line fault", line_fault, 3'b001 << p);
				chk("line alarm", line_alarm, 3'b001 << p);
			end
			r1l <= 18'sd0;
			phl <= '0;
			idle(4);
		end
	endtask : t_class

	// Inverse time on stage one: plain family, then a steep family whose k is raised to its floor.
	task automatic t_idmt();
		logic [1:0] r;
		int n, ex, need;
		ex = (2000 * 2000 - 1000 * 1000) >> EXCESS_SHIFT;
		for (int f = 0; f < 2; f++)
		begin
			wr(sa(0, 0), cfg(1000, 0, 0) | (32'h1 << CFG_IDMT) | (32'(f) << CFG_FAM), r);
			wr(sa(0, 0) + 12'h004, (32'(K_MIN) << TIM_K) | 32'h4, r);
			need = (int'(f ? K_MIN_STEEP : K_MIN) * int'(CURVE_C[0]) + ex - 1) / ex;
			r1l <= 18'sd2000;
			wait_bit(0, 0, 1'b1, n);
			wait_bit(1, 0, 1'b1, n);
			chk("inverse trip time", n > (need - 1) * TK && n <= need * TK, 1);
			r1l <= 18'sd0;
			idle(4);
		end
	endtask : t_idmt

	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = 4'hf;
		r1l = '0;
		r2l = '0;
		phl = '0;
		err_count = 0;
		cmp_count = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		idle(2);
		t_regs();
		t_trip();
		t_group();
		t_source();
		t_class();
		t_idmt();
		wrap_up();
	end
endmodule : tb_earth_fault_overcurrent_stages
`default_nettype wire

// [verilog/earth_fault_overcurrent_stages.sv]
// Four earth fault overcurrent stages with faulted-phase identification and AXI4-Lite settings.
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`default_nettype none
module earth_fault_overcurrent_stages
	import efo_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = DLY_STEP_NS / CLK_NS
) (
	input  wire logic              aclk,          // System clock.
	input  wire logic              aresetn,       // Synchronous reset, low.
	input  wire logic [AXI_AW-1:0] awaddr,        // Write address.
	input  wire logic              awvalid,       // Write address valid.
	output logic                   awready,       // Write address ready.
	input  wire logic [31:0]       wdata,         // Write data.
	input  wire logic [3:0]        wstrb,         // Write byte strobes.
	input  wire logic              wvalid,        // Write data valid.
	output logic                   wready,        // Write data ready.
	output logic [1:0]             bresp,         // Write response.
	output logic                   bvalid,        // Write response valid.
	input  wire logic              bready,        // Write response ready.
	input  wire logic [AXI_AW-1:0] araddr,        // Read address.
	input  wire logic              arvalid,       // Read address valid.
	output logic                   arready,       // Read address ready.
	output logic [31:0]            rdata,         // Read data.
	output logic [1:0]             rresp,         // Read response.
	output logic                   rvalid,        // Read data valid.
	input  wire logic              rready,        // Read data ready.
	input  wire phasor_t           residual_input_one, // Residual one phasor.
	input  wire phasor_t           residual_input_two, // Residual two phasor.
	input  wire phasor_t [2:0]     phase_cur,     // Phase L1..L3 phasors.
	output logic [3:0]             start,         // Stage start levels.
	output logic [3:0]             trip,          // Stage trip levels.
	output logic [2:0]             line_alarm,    // Faulted phases, started.
	output logic [2:0]             line_fault,    // Faulted phases, tripped.
	output logic                   event_valid,   // Classification event pulse.
	output logic [1:0]             event_stage,   // Stage of the event.
	output class_t                 event_code     // Faulted-phase result.
);
	if (TICK_CYCLES < 1 || TICK_CYCLES > 32'd1048576)
		$error("TICK_CYCLES must lie in 1..2**20");

	typedef struct packed {
		logic [1:0]                grp;
		logic [15:0][31:0]         cfg;
		logic [15:0][31:0]         tim;
		stage_st_t [3:0]           ss;
		logic [3:0][39:0]          cnt;
		logic [19:0]               tick;
		logic [2:0][MW-1:0]        pm;
		logic [2:0][MW-1:0]        pmd;
		logic [MW-1:0]             i1m;
		logic [MW-1:0]             i2m;
		logic [MW-1:0]             i2d;
		logic [2:0][MW-1:0]        rm;
		logic [3:0][2:0][MW-1:0]   pre;
		logic [3:0][MW-1:0]        pre2;
		logic [3:0][3:0]           cls;
		logic [3:0]                start;
		logic [3:0]                trip;
		logic [2:0]                line_alarm;
		logic [2:0]                line_fault;
		logic                      ev_valid;
		logic [1:0]                ev_stage;
		class_t                    ev_code;
		logic                      awready;
		logic                      bvalid;
		logic [1:0]                bresp;
		logic                      arready;
		logic                      rvalid;
		logic [31:0]               rdata;
		logic [1:0]                rresp;
	} state_t;

	localparam state_t S_RST = '{cfg: {16{CFG_RST}}, tim: {16{TIM_RST}}, ss: {4{ST_IDLE}},
		ev_code: CL_L1N, default: '0};

	state_t s;
	state_t next_s;

	function automatic logic signed [SW-1:0] clip(input logic signed [PW-1:0] v,
		input logic [PW-1:0] lim);
		logic signed [SW-1:0] x;
		x = SW'(v);
		if (x > $signed(SW'(lim)))
			x = $signed(SW'(lim));
		else if (x < -$signed(SW'(lim)))
			x = -$signed(SW'(lim));
		return x;
	endfunction : clip

	function automatic logic [MW-1:0] mag2(input logic signed [SW-1:0] re,
		input logic signed [SW-1:0] im);
		// Operands are widened first so that the squares cannot wrap at input width.
		return MW'(re) * MW'(re) + MW'(im) * MW'(im);
	endfunction : mag2

	// Rotation by a (conj = 0) or a squared (conj = 1); 0.866 kept as 222/256.
	function automatic logic [2*SW-1:0] rot(input logic signed [SW-1:0] x,
		input logic signed [SW-1:0] y, input logic conj);
		logic signed [SW-1:0] hx;
		logic signed [SW-1:0] hy;
		logic signed [SW-1:0] sx;
		logic signed [SW-1:0] sy;
		hx = x >>> 1;
		hy = y >>> 1;
		sx = SW'((32'(x) * $signed(32'(ROT_NUM))) >>> 8);
		sy = SW'((32'(y) * $signed(32'(ROT_NUM))) >>> 8);
		if (conj)
			return {SW'(sy - hx), SW'(-sx - hy)};
		return {SW'(-hx - sy), SW'(sx - hy)};
	endfunction : rot

	function automatic class_t classify(input logic [2:0][MW-1:0] pr,
		input logic [2:0][MW-1:0] cu, input logic [MW-1:0] c1,
		input logic [MW-1:0] c2, input logic iso);
		logic signed [MW:0]        d [3];
		logic signed [MW:0] mx;
		logic [2:0] m;
		mx = '0;
		m = '0;
		for (int p = 0; p < 3; p++)
		begin
			d[p] = $signed({1'b0, cu[p]}) - $signed({1'b0, pr[p]});
			if (d[p] > mx)
				mx = d[p];
		end
		// Isolated networks see a weak change on the healthy phases, so a lower share counts.
		for (int p = 0; p < 3; p++)
			m[p] = (d[p] > 0) && ((iso ? (d[p] <<< 2) : (d[p] <<< 1)) >= mx);
		if (mx == '0)
			return CL_REV;
		if (m != 3'b001 && m != 3'b010 && m != 3'b100 && (c2 << 4) < c1)
			return CL_L123N;
		unique case (m)
			3'b001: return CL_L1N;
			3'b010: return CL_L2N;
			3'b100: return CL_L3N;
			3'b011: return CL_L12N;
			3'b101: return CL_L13N;
			3'b110: return CL_L23N;
			3'b111: return CL_L123N;
			default: return CL_REV;
		endcase
	endfunction : classify

	function automatic logic [2:0] code_mask(input logic [3:0] c);
		if (!c[3])
			return 3'h0;
		unique case (class_t'(c[2:0]))
			CL_L1N: return 3'h1;
			CL_L2N: return 3'h2;
			CL_L3N: return 3'h4;
			CL_L12N: return 3'h3;
			CL_L13N: return 3'h5;
			CL_L23N: return 3'h6;
			CL_L123N: return 3'h7;
			CL_REV: return 3'h0;
		endcase
	endfunction : code_mask

	logic signed [2:0][SW-1:0] pre_re;
	logic signed [2:0][SW-1:0] pre_im;
	logic [3:0][MW-1:0]        mag;
	logic [3:0][MW-1:0]        thr2;
	logic [3:0]                over;
	logic [3:0]                keep;
	logic [3:0]                fpd_en;
	logic [3:0][15:0]          thr;
	logic [15:0]               thr_r;
	logic [14:0]               dly;
	logic [14:0]               kset;
	logic [39:0]               acc;
	logic [3:0]                idx;
	logic [31:0]               c;
	logic [31:0]               t;
	logic [2:0]                fam;
	logic                      tk;
	logic [2*SW-1:0]           ra;
	logic [2*SW-1:0]           rb;
	logic [2*SW-1:0]           rc;
	logic [2*SW-1:0]           rd;
	logic [31:0]               wm;
	logic [3:0]                ent;

	always_comb
	begin
		next_s = s;
		next_s.ev_valid = 1'b0;
		next_s.awready = 1'b0;
		next_s.arready = 1'b0;
		tk = (s.tick == 20'(TICK_CYCLES - 1));
		next_s.tick = tk ? '0 : s.tick + 20'h00001;
		for (int p = 0; p < 3; p++)
		begin
			pre_re[p] = clip(phase_cur[p].re, PH_SAT);
			pre_im[p] = clip(phase_cur[p].im, PH_SAT);
			next_s.pm[p] = mag2(pre_re[p], pre_im[p]);
		end
		next_s.pmd = s.pm;
		// Inputs are fundamental phasors, so third-harmonic content never reaches a compare.
		next_s.rm[0] = mag2(clip(residual_input_one.re, RES_SAT),
			clip(residual_input_one.im, RES_SAT));
		next_s.rm[1] = mag2(clip(residual_input_two.re, RES_SAT),
			clip(residual_input_two.im, RES_SAT));
		next_s.rm[2] = mag2(pre_re[0] + pre_re[1] + pre_re[2],
			pre_im[0] + pre_im[1] + pre_im[2]);
		ra = rot(pre_re[1], pre_im[1], 1'b0);
		rb = rot(pre_re[2], pre_im[2], 1'b1);
		rc = rot(pre_re[1], pre_im[1], 1'b1);
		rd = rot(pre_re[2], pre_im[2], 1'b0);
		next_s.i1m = mag2(pre_re[0] + $signed(ra[2*SW-1:SW]) + $signed(rb[2*SW-1:SW]),
			pre_im[0] + $signed(ra[SW-1:0]) + $signed(rb[SW-1:0]));
		next_s.i2m = mag2(pre_re[0] + $signed(rc[2*SW-1:SW]) + $signed(rd[2*SW-1:SW]),
			pre_im[0] + $signed(rc[SW-1:0]) + $signed(rd[SW-1:0]));
		next_s.i2d = s.i2m;
		for (int i = 0; i < 4; i++)
		begin
			idx = {s.grp, 2'(i)};
			c = s.cfg[idx];
			t = s.tim[idx];
			fam = c[CFG_FAM+:3];
			fpd_en[i] = c[CFG_FPD];
			unique case (c[CFG_SRC+:2])
				SRC_R2: mag[i] = s.rm[1];
				SRC_CALC: mag[i] = s.rm[2];
				default: mag[i] = s.rm[0];
			endcase
			thr[i] = c[15:0];
			if (c[CFG_SRC+:2] == SRC_CALC)
			begin
				if (thr[i] < THR_MIN_CALC)
					thr[i] = THR_MIN_CALC;
				if (thr[i] > THR_MAX_CALC)
					thr[i] = THR_MAX_CALC;
			end
			else
			begin
				if (i == 0 && thr[i] < THR_MIN_FIRST)
					thr[i] = THR_MIN_FIRST;
				if (i != 0 && thr[i] < THR_MIN_OTHER)
					thr[i] = THR_MIN_OTHER;
				if (thr[i] > THR_MAX_MEAS)
					thr[i] = THR_MAX_MEAS;
			end
			if (i != 0)
				thr[i] = thr[i] - (thr[i] % THR_STEP_OTHER);
			thr2[i] = MW'(thr[i]) * MW'(thr[i]);
			thr_r = 16'((25'(thr[i]) * 25'(HYST_NUM)) >> 8);
			over[i] = mag[i] > thr2[i];
			keep[i] = mag[i] >= MW'(thr_r) * MW'(thr_r);
			dly = t[14:0];
			if (dly < DLY_MIN)
				dly = DLY_MIN;
			if (dly > DLY_MAX)
				dly = DLY_MAX;
			kset = t[TIM_K+:15];
			if (kset < ((fam == FAM_IEEE || fam == FAM_LOG) ? K_MIN_STEEP : K_MIN))
				kset = (fam == FAM_IEEE || fam == FAM_LOG) ? K_MIN_STEEP : K_MIN;
			if (kset > K_MAX)
				kset = K_MAX;
			acc = s.cnt[i] + 40'(over[i] ? (mag[i] - thr2[i]) >> EXCESS_SHIFT : '0);
			unique case (s.ss[i])
				ST_IDLE:
				begin
					if (over[i])
					begin
						next_s.ss[i] = ST_START;
						next_s.cnt[i] = '0;
						next_s.pre[i] = s.pmd;
						next_s.pre2[i] = s.i2d;
					end
				end
				ST_START:
				begin
					if (!keep[i])
					begin
						next_s.ss[i] = ST_IDLE;
						next_s.cnt[i] = '0;
					end
					else if (tk)
					begin
						// Inverse time integrates the excess of the squared magnitude over the squared threshold against k times the shape's constant.
						if (i == 0 && c[CFG_IDMT])
						begin
							next_s.cnt[i] = acc;
							if (acc >= 40'(kset) * 40'(CURVE_C[(c[CFG_SHP+:3] > 3'h4) ? 3'h4
								: c[CFG_SHP+:3]]))
								next_s.ss[i] = ST_TRIP;
						end
						else
						begin
							next_s.cnt[i] = s.cnt[i] + 40'h1;
							if (s.cnt[i] + 40'h1 >= 40'(dly))
								next_s.ss[i] = ST_TRIP;
						end
						if (next_s.ss[i] == ST_TRIP)
						begin
							next_s.cls[i] = 4'h0;
							if (fpd_en[i])
							begin
								next_s.cls[i] = {1'b1, classify(s.pre[i], s.pm, s.i1m,
									s.i2m, c[CFG_ISO])};
								next_s.ev_valid = 1'b1;
								next_s.ev_stage = 2'(i);
								next_s.ev_code = class_t'(next_s.cls[i][2:0]);
							end
						end
					end
				end
				ST_TRIP:
				begin
					if (!keep[i])
					begin
						next_s.ss[i] = ST_IDLE;
						next_s.cnt[i] = '0;
					end
				end
				default: next_s.ss[i] = ST_IDLE;
			endcase
		end
		next_s.line_alarm = '0;
		next_s.line_fault = '0;
		for (int i = 0; i < 4; i++)
		begin
			next_s.start[i] = next_s.ss[i] != ST_IDLE;
			next_s.trip[i] = next_s.ss[i] == ST_TRIP;
			if (next_s.start[i])
				next_s.line_alarm = next_s.line_alarm | code_mask(next_s.cls[i]);
			if (next_s.trip[i])
				next_s.line_fault = next_s.line_fault | code_mask(next_s.cls[i]);
		end
		// Write: ready is raised only when both channels are offered, response follows the take.
		wm = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
		ent = awaddr[6:3];
		if (s.bvalid && bready)
			next_s.bvalid = 1'b0;
		if (awvalid && wvalid && !s.awready && !s.bvalid)
			next_s.awready = 1'b1;
		if (s.awready)
		begin
			next_s.bvalid = 1'b1;
			next_s.bresp = BR_OKAY;
			if (awaddr[11:2] == CTRL_OFF[11:2])
			begin
				if (wstrb[0])
					next_s.grp = wdata[1:0];
			end
			else if (awaddr[11:8] == SET_PAGE && !awaddr[7])
			begin
				if (awaddr[2])
					next_s.tim[ent] = (s.tim[ent] & ~wm) | (wdata & wm);
				else
					next_s.cfg[ent] = (s.cfg[ent] & ~wm) | (wdata & wm);
			end
			else if (awaddr[11:2] != STATUS_OFF[11:2] && awaddr[11:2] != CLASS_OFF[11:2])
				next_s.bresp = BR_SLVERR;
		end
		if (s.rvalid && rready)
			next_s.rvalid = 1'b0;
		if (arvalid && !s.arready && !s.rvalid)
			next_s.arready = 1'b1;
		if (s.arready)
		begin
			next_s.rvalid = 1'b1;
			next_s.rresp = BR_OKAY;
			next_s.rdata = '0;
			if (araddr[11:2] == CTRL_OFF[11:2])
				next_s.rdata = {30'h0, s.grp};
			else if (araddr[11:2] == STATUS_OFF[11:2])
				next_s.rdata = {24'h0, s.trip, s.start};
			else if (araddr[11:2] == CLASS_OFF[11:2])
				next_s.rdata = {16'h0, s.cls};
			else if (araddr[11:8] == SET_PAGE && !araddr[7])
				next_s.rdata = araddr[2] ? s.tim[araddr[6:3]] : s.cfg[araddr[6:3]];
			else
				next_s.rresp = BR_SLVERR;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= S_RST;
		else
			s <= next_s;
	end

	assign awready = s.awready;
	assign wready = s.awready;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = s.arready;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign start = s.start;
	assign trip = s.trip;
	assign line_alarm = s.line_alarm;
	assign line_fault = s.line_fault;
	assign event_valid = s.ev_valid;
	assign event_stage = s.ev_stage;
	assign event_code = s.ev_code;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	start_on_over_a: assert property (over[0] && s.ss[0] == ST_IDLE |=> start[0])
		else $error("stage one missed its start");
	trip_needs_start_a: assert property (trip[2] |-> start[2] && s.cnt[2] >= 40'(DLY_MIN))
		else $error("stage three tripped early");
	dt_delay_met_a: assert property ($rose(s.trip[1]) && !s.cfg[{s.grp, 2'h1}][CFG_IDMT]
		|-> s.cnt[1] >= 40'(DLY_MIN))
		else $error("definite delay shorter than minimum");
	reset_clears_a: assert property (!keep[3] && start[3] |=> !start[3] && s.cnt[3] == '0)
		else $error("stage four did not drop out");
	clip_residual_a: assert property (s.rm[0] <= 2 * MW'(RES_SAT) * MW'(RES_SAT))
		else $error("residual one beyond saturation");
	prefault_hold_a: assert property ($rose(s.start[0]) |-> s.pre[0] == $past(s.pmd))
		else $error("pre-fault set not captured");
	no_class_off_a: assert property (event_valid |->
		(($past(fpd_en) >> event_stage) & 4'h1) != 4'h0)
		else $error("classification while disabled");
	bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
endmodule : earth_fault_overcurrent_stages
`default_nettype wire

// [verilog/efo_pkg.sv]
// Shared types, register map and limits of the earth fault overcurrent stages.
`default_nettype none
package efo_pkg;
	localparam int PW = 18;
	localparam int SW = 22;
	localparam int MW = 46;
	localparam int AXI_AW = 12;
	typedef struct packed {
		logic signed [PW-1:0] re;
		logic signed [PW-1:0] im;
	} phasor_t;
	typedef enum logic [2:0] {
		CL_L1N = 3'h0, CL_L2N = 3'h1, CL_L3N = 3'h2, CL_L12N = 3'h3,
		CL_L13N = 3'h4, CL_L23N = 3'h5, CL_L123N = 3'h6, CL_REV = 3'h7
	} class_t;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_START = 2'b01, ST_TRIP = 2'b11} stage_st_t;
	localparam logic [1:0] SRC_R1 = 2'h0;
	localparam logic [1:0] SRC_R2 = 2'h1;
	localparam logic [1:0] SRC_CALC = 2'h2;
	localparam logic [2:0] FAM_IEEE = 3'h1;
	localparam logic [2:0] FAM_LOG = 3'h4;
	localparam logic [11:0] CTRL_OFF = 12'h000;
	localparam logic [11:0] STATUS_OFF = 12'h004;
	localparam logic [11:0] CLASS_OFF = 12'h008;
	localparam logic [3:0] SET_PAGE = 4'h1;
	localparam int CFG_SRC = 16;
	localparam int CFG_IDMT = 18;
	localparam int CFG_FAM = 19;
	localparam int CFG_SHP = 22;
	localparam int CFG_FPD = 25;
	localparam int CFG_ISO = 26;
	localparam int TIM_K = 16;
	localparam logic [31:0] CFG_RST = 32'h0000_03e8;
	localparam logic [31:0] TIM_RST = 32'h03e8_0004;
	localparam logic [15:0] THR_MIN_FIRST = 16'h0005;
	localparam logic [15:0] THR_MIN_OTHER = 16'h000a;
	localparam logic [15:0] THR_STEP_OTHER = 16'h000a;
	localparam logic [15:0] THR_MAX_MEAS = 16'h1f40;
	localparam logic [15:0] THR_MIN_CALC = 16'h0032;
	localparam logic [15:0] THR_MAX_CALC = 16'h4e20;
	localparam logic [PW-1:0] RES_SAT = 18'h02710;
	localparam logic [PW-1:0] PH_SAT = 18'h0c350;
	localparam int CLK_NS = 10;
	localparam int DLY_STEP_NS = 10_000_000;
	localparam logic [14:0] DLY_MIN = 15'h0004;
	localparam logic [14:0] DLY_MAX = 15'h7530;
	localparam logic [14:0] K_MIN = 15'h0019;
	localparam logic [14:0] K_MIN_STEEP = 15'h01f4;
	localparam logic [14:0] K_MAX = 15'h4e20;
	localparam logic [8:0] HYST_NUM = 9'h0f3;
	localparam logic [8:0] ROT_NUM = 9'h0de;
	localparam int EXCESS_SHIFT = 10;
	localparam logic [4:0][15:0] CURVE_C = {16'h2ee0, 16'h0320, 16'h05dc, 16'h0b72, 16'h03e8};
	localparam logic [1:0] BR_OKAY = 2'h0;
	localparam logic [1:0] BR_SLVERR = 2'h2;
endpackage : efo_pkg
`default_nettype wire
